// ---- hdl/fps_pkg.sv ----
package fps_pkg;

  // rounding mode codes on {hi,lo}
  localparam logic [1:0] RM_NEAR = 2'h0;
  localparam logic [1:0] RM_ZERO = 2'h1;
  localparam logic [1:0] RM_POS  = 2'h2;
  localparam logic [1:0] RM_NEG  = 2'h3;

  // chain status source codes
  localparam logic [1:0] CSS_ALU  = 2'h0;
  localparam logic [1:0] CSS_MUL  = 2'h1;
  localparam logic [1:0] CSS_BOTH = 2'h2;

  // exception vector layout, also the mask layout
  localparam int EXC_W   = 5;
  localparam int EXC_INV = 0;
  localparam int EXC_DIV = 1;
  localparam int EXC_OVF = 2;
  localparam int EXC_UNF = 3;
  localparam int EXC_INX = 4;

  // raw core flag layout
  localparam int RAW_W   = 4;
  localparam int RAW_INV = 0;
  localparam int RAW_DIV = 1;
  localparam int RAW_OVF = 2;
  localparam int RAW_TNY = 3;

  localparam logic [EXC_W-1:0] MASK_RST = 5'h00;
  localparam logic [1:0]       SYNC_RST = 2'h0;

  // pipeline stage one contents
  typedef struct packed {
    logic [63:0]      a;
    logic [63:0]      b;
    logic [63:0]      alu_res;
    logic [63:0]      mul_res;
    logic [2:0]       alu_grs;
    logic [2:0]       mul_grs;
    logic [RAW_W-1:0] alu_raw;
    logic [RAW_W-1:0] mul_raw;
    logic [1:0]       rmode;
    logic [1:0]       css;
    logic             alu_sub;
    logic             mul_wrap;
    logic             mul_a_spec;
    logic             mul_b_spec;
    logic             mul_den;
    logic             mul_nan;
    logic             flush;
    logic             compare;
    logic             chain;
    logic             bit6;
    logic             op_mul;
    logic             half_hi;
    logic             single;
  } fps_s1_s;

  // status register contents
  typedef struct packed {
    logic [EXC_W-1:0] exc;
    logic             incr;
    logic             eq;
    logic             gt;
    logic             nan_compare_flag;
    logic             chain_exception_source;
    logic             den_in;
    logic             subn;
    logic             result_unbounded_flag;
    logic             neg;
    logic             origin_mul;
    logic             a_spec;
    logic             b_spec;
    logic             src_mul;
    logic             half_hi;
    logic             single;
  } fps_st_s;

  function automatic logic fps_nan(input logic [63:0] x);
    return (&x[62:52]) && (|x[51:0]);
  endfunction

  function automatic logic fps_sub(input logic [63:0] x);
    return (~|x[62:52]) && (|x[51:0]);
  endfunction

  function automatic logic fps_gt(input logic [63:0] a, input logic [63:0] b);
    if (a[63] != b[63])
      return !a[63] && (|{a[62:0], b[62:0]});
    else if (!a[63])
      return a[62:0] > b[62:0];
    else
      return a[62:0] < b[62:0];
  endfunction

endpackage

// ---- hdl/fps_stage_if.sv ----
`timescale 1ns/1ps
interface fps_stage_if #(parameter int W = 1);
  logic [W-1:0] d;
  logic [W-1:0] q;
  logic         flow;
  logic         hold;
  modport stage (input d, input flow, input hold, output q);
  modport ctrl  (output d, output flow, output hold, input q);
endinterface

// ---- hdl/fps_pipe_stage.sv ----
`timescale 1ns/1ps
module fps_pipe_stage
  import fps_pkg::*;
#(
  parameter int W     = 1,
  parameter bit CLEAR = 1'b1
)(
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  fps_stage_if.stage  s
);
  typedef struct packed {
    logic [W-1:0] r;
  } fps_stg_s;

  fps_stg_s st;
  fps_stg_s next_st;

  if (W < 1) $error("stage width must be positive");

  // flowthrough bypasses the register, which still loads d unless held
  assign s.q = s.flow ? s.d : st.r;

  // hold keeps contents during a stall
  always_comb
  begin
    next_st = st;
    if (!s.hold)
      next_st.r = s.d;
  end

  // data-only stages keep contents across reset
  if (CLEAR)
  begin : g_clr
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        st <= '0;
      else
        st <= next_st;
    end
  end
  else
  begin : g_keep
    always_ff @(posedge clk_i)
    begin
      st <= next_st;
    end
  end

  flow_pass_a: assert property (@(posedge clk_i) s.flow |-> s.q == s.d) // RL1
    else $error("flowthrough stage does not pass data");
endmodule

// ---- hdl/fps_round.sv ----
`timescale 1ns/1ps
module fps_round
  import fps_pkg::*;
(
  input  wire logic [1:0] mode_i,
  input  wire logic       sign_i,
  input  wire logic       lsb_i,
  input  wire logic [2:0] grs_i,
  output logic            incr_o,
  output logic            inexact_o
);
  // grs_i is guard, round, sticky from msb down
  always_comb
  begin
    inexact_o = |grs_i;
    case (mode_i) // RL5
      RM_NEAR: incr_o = grs_i[2] && (|grs_i[1:0] || lsb_i);
      RM_ZERO: incr_o = 1'b0;
      RM_POS:  incr_o = !sign_i && inexact_o;
      RM_NEG:  incr_o = sign_i && inexact_o;
      default: incr_o = 1'b0;
    endcase
  end
endmodule

// ---- hdl/fps_status_top.sv ----
`timescale 1ns/1ps
// Contract
// RL1: pipe enable low registers ALU/multiplier pipeline; high makes it flowthrough.
// RL2: result enable low registers status, P and S; high makes them flowthrough.
// RL3: reset clears internal state, status and exception mask, dropping pipeline data.
// RL4: reset leaves C, P and S data registers unchanged.
// RL5: two rounding bits pick one of four IEEE rounding modes.
// RL6: round-increment flag high when rounding grew the mantissa magnitude.
// RL7: controller drives the eight-bit operand source select.
// RL8: chain status select picks which unit reports status during chaining.
// RL9: half select low gives low 32 bits on Y, high gives upper; code gives low 32 bits in single precision either way.
// RL10: C loads from ALU when select low, multiplier when high.
// RL11: equal flag: A equals B on compare, else Y result zero.
// RL12: greater flag high when operand A exceeds operand B.
// RL13: chain exception names source: bit6 low multiplier, high ALU.
// RL14: multiplier subnormal input raises flag; port flags show A or B.
// RL15: subnormal output flag for ALU subnormal or multiplier wrapped result.
// RL16: sudden underflow with subnormal output forces result to zero.
// RL17: divide-by-zero flag on any attempted division by zero.
// RL18: any-exception flag is OR of exceptions enabled by the mask.
// RL19: invalid flag on invalid operation or NaN at either unit input.
// RL20: overflow flag when result exceeds format maximum.
// RL21: underflow flag when result is inexact and below format minimum.
// RL22: unordered flag when either compared input is NaN.
// RL23: sudden underflow forces subnormal inputs and outputs to zero.
// RL24: stall low freezes pipeline and status; C follows its own enable.
// RL25: status pins driven only while status enable low, else released.
module fps_status_top
  import fps_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic              alu_mul_pipe_enable_n_i,
  input  wire logic              result_stage_pipe_enable_n_i,
  input  wire logic              stall_n_i,
  input  wire logic              sudden_underflow_i,
  input  wire logic              round_mode_bit_lo_i,
  input  wire logic              round_mode_bit_hi_i,
  input  wire logic [1:0]        chain_status_select_i,
  input  wire logic              result_half_select_i,
  input  wire logic              c_reg_source_select_i,
  input  wire logic              c_write_enable_n_i,
  input  wire logic              status_output_enable_n_i,
  input  wire logic              instruction_bit6_i,
  input  wire logic              chain_mode_i,
  input  wire logic              compare_op_i,
  input  wire logic              mul_op_i,
  input  wire logic              single_prec_i,
  input  wire logic              mask_write_i,
  input  wire logic [EXC_W-1:0]  mask_data_i,
  input  wire logic [63:0]       op_a_i,
  input  wire logic [63:0]       op_b_i,
  input  wire logic [63:0]       mul_a_i,
  input  wire logic [63:0]       mul_b_i,
  input  wire logic [63:0]       alu_result_i,
  input  wire logic [63:0]       mul_result_i,
  input  wire logic [2:0]        alu_grs_i,
  input  wire logic [2:0]        mul_grs_i,
  input  wire logic [RAW_W-1:0]  alu_raw_i,
  input  wire logic [RAW_W-1:0]  mul_raw_i,
  input  wire logic              alu_subnormal_i,
  input  wire logic              mul_wrapped_i,
  output logic [31:0]            y_o,
  output logic [63:0]            c_reg_o,
  output logic                   status_oe_n_o,
  output logic                   round_increment_flag_o,
  output logic                   operands_equal_flag_o,
  output logic                   a_greater_flag_o,
  output logic                   chain_exception_source_o,
  output logic                   multiplier_subnormal_input_flag_o,
  output logic                   subnormal_output_flag_o,
  output logic                   divide_by_zero_flag_o,
  output logic                   any_exception_flag_o,
  output logic                   imprecise_result_flag_o,
  output logic                   result_unbounded_flag_o,
  output logic                   invalid_operation_flag_o,
  output logic                   result_sign_flag_o,
  output logic                   exception_origin_flag_o,
  output logic                   b_port_special_input_flag_o,
  output logic                   a_port_special_input_flag_o,
  output logic                   overflow_flag_o,
  output logic                   underflow_flag_o,
  output logic                   nan_compare_flag_o
);
  typedef struct packed {
    logic [EXC_W-1:0] mask;
    logic [63:0]      c;
    logic [31:0]      y;
    fps_st_s          fl;
    logic             ed;
    logic             oe_n;
  } fps_top_s;

  fps_top_s           st;
  fps_top_s           next_st;
  logic [1:0]         rsync;
  logic               rst_n;
  fps_s1_s            s1;
  fps_s1_s            s1_d;
  fps_st_s            s2;
  fps_st_s            s2_d;
  logic [127:0]       ps_d;
  logic [63:0]        p_q;
  logic [63:0]        s_q;
  logic [63:0]        r_q;
  logic [63:0]        alu_rnd;
  logic [63:0]        mul_rnd;
  logic [63:0]        r;
  logic               alu_incr;
  logic               mul_incr;
  logic               alu_inx;
  logic               mul_inx;
  logic               src_mul;
  logic               both;
  logic [EXC_W-1:0]   exc_alu;
  logic [EXC_W-1:0]   exc_mul;
  logic [EXC_W-1:0]   s2_exc;

  fps_stage_if #(.W($bits(fps_s1_s))) s1_if ();
  fps_stage_if #(.W($bits(fps_st_s))) st_if ();
  fps_stage_if #(.W(128))             ps_if ();

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rsync <= SYNC_RST;
    else
      rsync <= {rsync[0], 1'b1};
  end
  assign rst_n = rsync[1];

  // stage one input: operand flush and unit flags
  always_comb
  begin
    s1_d            = '0;
    s1_d.flush      = sudden_underflow_i;
    s1_d.a          = (sudden_underflow_i && fps_sub(op_a_i)) // RL23
                      ? {op_a_i[63], 63'h0} : op_a_i;
    s1_d.b          = (sudden_underflow_i && fps_sub(op_b_i)) // RL23
                      ? {op_b_i[63], 63'h0} : op_b_i;
    s1_d.alu_res    = alu_result_i;
    s1_d.mul_res    = mul_result_i;
    s1_d.alu_grs    = alu_grs_i;
    s1_d.mul_grs    = mul_grs_i;
    s1_d.alu_raw    = alu_raw_i;
    s1_d.mul_raw    = mul_raw_i;
    s1_d.rmode      = {round_mode_bit_hi_i, round_mode_bit_lo_i};
    s1_d.css        = chain_status_select_i;
    s1_d.alu_sub    = alu_subnormal_i;
    s1_d.mul_wrap   = mul_wrapped_i;
    s1_d.mul_a_spec = fps_sub(mul_a_i) || fps_nan(mul_a_i) || fps_nan(op_a_i); // RL14
    s1_d.mul_b_spec = fps_sub(mul_b_i) || fps_nan(mul_b_i) || fps_nan(op_b_i); // RL14
    s1_d.mul_den    = fps_sub(mul_a_i) || fps_sub(mul_b_i); // RL14
    s1_d.mul_nan    = fps_nan(mul_a_i) || fps_nan(mul_b_i);
    s1_d.compare    = compare_op_i;
    s1_d.chain      = chain_mode_i;
    s1_d.bit6       = instruction_bit6_i;
    s1_d.op_mul     = mul_op_i;
    s1_d.half_hi    = result_half_select_i;
    s1_d.single     = single_prec_i;
  end
  assign s1_if.d = s1_d;

  // stall freezes all three stages; reset drops stage one and the status stage
  assign s1_if.flow = alu_mul_pipe_enable_n_i; // RL1
  assign s1_if.hold = !stall_n_i; // RL24
  assign st_if.flow = result_stage_pipe_enable_n_i; // RL2
  assign st_if.hold = !stall_n_i; // RL24
  assign ps_if.flow = result_stage_pipe_enable_n_i; // RL2
  assign ps_if.hold = !stall_n_i; // RL24
  assign s1 = s1_if.q;
  assign s2 = st_if.q;
  assign s2_exc = s2.exc;
  assign {p_q, s_q} = ps_if.q;

  fps_pipe_stage #(.W($bits(fps_s1_s)), .CLEAR(1'b1)) u_s1 (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .s       (s1_if.stage)
  );

  fps_pipe_stage #(.W($bits(fps_st_s)), .CLEAR(1'b1)) u_st (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .s       (st_if.stage)
  );

  // product and sum survive reset, unlike status
  fps_pipe_stage #(.W(128), .CLEAR(1'b0)) u_ps ( // RL4
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .s       (ps_if.stage)
  );

  fps_round u_alu_rnd (
    .mode_i    (s1.rmode),
    .sign_i    (s1.alu_res[63]),
    .lsb_i     (s1.alu_res[0]),
    .grs_i     (s1.alu_grs),
    .incr_o    (alu_incr),
    .inexact_o (alu_inx)
  );

  fps_round u_mul_rnd (
    .mode_i    (s1.rmode),
    .sign_i    (s1.mul_res[63]),
    .lsb_i     (s1.mul_res[0]),
    .grs_i     (s1.mul_grs),
    .incr_o    (mul_incr),
    .inexact_o (mul_inx)
  );

  // rounding carry may ripple into the exponent, as IEEE intends
  always_comb
  begin
    alu_rnd = s1.alu_res + {63'h0, alu_incr}; // RL6
    mul_rnd = s1.mul_res + {63'h0, mul_incr}; // RL6
    if (s1.flush && s1.alu_sub)
      alu_rnd = {s1.alu_res[63], 63'h0}; // RL16
    if (s1.flush && s1.mul_wrap)
      mul_rnd = {s1.mul_res[63], 63'h0}; // RL16
  end
  assign ps_d = {mul_rnd, alu_rnd};
  assign ps_if.d = ps_d;

  // status source and per-unit exception vectors
  always_comb
  begin
    both    = s1.chain && (s1.css == CSS_BOTH); // RL8
    src_mul = s1.chain ? (s1.css == CSS_MUL) : s1.op_mul; // RL8
    r       = src_mul ? mul_rnd : alu_rnd;
    exc_alu = '0;
    exc_alu[EXC_INV] = s1.alu_raw[RAW_INV] || fps_nan(s1.a) || fps_nan(s1.b); // RL19
    exc_alu[EXC_DIV] = s1.alu_raw[RAW_DIV]; // RL17
    exc_alu[EXC_OVF] = s1.alu_raw[RAW_OVF]; // RL20
    exc_alu[EXC_UNF] = s1.alu_raw[RAW_TNY] && alu_inx; // RL21
    exc_alu[EXC_INX] = alu_inx;
    exc_mul = '0;
    exc_mul[EXC_INV] = s1.mul_raw[RAW_INV] || s1.mul_nan; // RL19
    exc_mul[EXC_DIV] = s1.mul_raw[RAW_DIV]; // RL17
    exc_mul[EXC_OVF] = s1.mul_raw[RAW_OVF]; // RL20
    exc_mul[EXC_UNF] = s1.mul_raw[RAW_TNY] && mul_inx; // RL21
    exc_mul[EXC_INX] = mul_inx;
  end

  // status register input
  always_comb
  begin
    s2_d            = '0;
    s2_d.src_mul    = src_mul;
    s2_d.exc        = both ? (exc_alu | exc_mul) : (src_mul ? exc_mul : exc_alu); // RL8
    s2_d.incr       = src_mul ? mul_incr : alu_incr; // RL6
    s2_d.eq         = s1.compare // RL11
                      ? (!fps_nan(s1.a) && !fps_nan(s1.b)
                         && ((s1.a == s1.b) || (~|{s1.a[62:0], s1.b[62:0]})))
                      : (~|r[62:0]);
    s2_d.gt         = s1.compare && !fps_nan(s1.a) && !fps_nan(s1.b)
                      && fps_gt(s1.a, s1.b); // RL12
    s2_d.nan_compare_flag      = s1.compare && (fps_nan(s1.a) || fps_nan(s1.b)); // RL22
    s2_d.chain_exception_source       = s1.chain && (s1.bit6 ? (|exc_alu) : (|exc_mul)); // RL13
    s2_d.den_in     = s1.mul_den; // RL14
    s2_d.a_spec     = s1.mul_a_spec; // RL14
    s2_d.b_spec     = s1.mul_b_spec; // RL14
    s2_d.subn       = both ? (s1.alu_sub || s1.mul_wrap)
                      : (src_mul ? s1.mul_wrap : s1.alu_sub); // RL15
    s2_d.result_unbounded_flag        = (&r[62:52]) && (~|r[51:0]);
    s2_d.neg        = r[63];
    s2_d.origin_mul = (|s2_d.exc) && (s1.chain ? !s1.bit6 : src_mul);
    s2_d.half_hi    = s1.half_hi;
    s2_d.single     = s1.single;
  end
  assign st_if.d = s2_d;

  assign r_q = s2.src_mul ? p_q : s_q;

  // output flops, mask and C register
  always_comb
  begin
    next_st      = st;
    next_st.fl   = s2;
    next_st.ed   = |(s2.exc & ~st.mask); // RL18
    next_st.oe_n = status_output_enable_n_i; // RL25
    next_st.y    = (s2.half_hi && !s2.single) ? r_q[63:32] : r_q[31:0]; // RL9
    if (mask_write_i && stall_n_i)
      next_st.mask = mask_data_i;
    if (!c_write_enable_n_i)
      next_st.c = c_reg_source_select_i ? p_q : s_q; // RL10
  end

  // C keeps its contents through reset on purpose
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.mask <= MASK_RST; // RL3
      st.y    <= '0;
      st.fl   <= '0; // RL3
      st.ed   <= 1'b0;
      st.oe_n <= 1'b1;
    end
    else
    begin
      st <= next_st; // RL4
    end
  end

  assign y_o                               = st.y;
  assign c_reg_o                           = st.c;
  assign status_oe_n_o                     = st.oe_n;
  assign round_increment_flag_o            = st.fl.incr;
  assign operands_equal_flag_o             = st.fl.eq;
  assign a_greater_flag_o                  = st.fl.gt;
  assign chain_exception_source_o          = st.fl.chain_exception_source;
  assign multiplier_subnormal_input_flag_o = st.fl.den_in;
  assign subnormal_output_flag_o           = st.fl.subn;
  assign divide_by_zero_flag_o             = st.fl.exc[EXC_DIV];
  assign any_exception_flag_o              = st.ed;
  assign imprecise_result_flag_o           = st.fl.exc[EXC_INX];
  assign result_unbounded_flag_o           = st.fl.result_unbounded_flag;
  assign invalid_operation_flag_o          = st.fl.exc[EXC_INV];
  assign result_sign_flag_o                = st.fl.neg;
  assign exception_origin_flag_o           = st.fl.origin_mul;
  assign b_port_special_input_flag_o       = st.fl.b_spec;
  assign a_port_special_input_flag_o       = st.fl.a_spec;
  assign overflow_flag_o                   = st.fl.exc[EXC_OVF];
  assign underflow_flag_o                  = st.fl.exc[EXC_UNF];
  assign nan_compare_flag_o                = st.fl.nan_compare_flag;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  pipe_hold_a: assert property ((!alu_mul_pipe_enable_n_i && !stall_n_i) // RL24
      ##1 !alu_mul_pipe_enable_n_i |-> $stable(s1))
    else $error("stage one changed during stall");
  stat_flow_a: assert property (result_stage_pipe_enable_n_i |-> s2 == s2_d) // RL2
    else $error("status stage not flowthrough");
  mask_reset_a: assert property ($rose(rst_n) |-> st.mask == MASK_RST) // RL3
    else $error("mask not cleared by reset");
  c_from_mul_a: assert property ((!c_write_enable_n_i && c_reg_source_select_i) // RL10
      |=> c_reg_o == $past(p_q))
    else $error("C did not load multiplier data");
  c_keep_a: assert property (c_write_enable_n_i ##1 c_write_enable_n_i // RL24
      |-> $stable(c_reg_o))
    else $error("C changed without write enable");
  y_half_a: assert property ((s2.half_hi && !s2.single) |=> y_o == $past(r_q[63:32])) // RL9
    else $error("upper half not on Y");
  ed_or_a: assert property (##1 any_exception_flag_o // RL18
      == |($past(s2_exc) & ~$past(st.mask)))
    else $error("exception detect mismatch");
  oe_follow_a: assert property (status_output_enable_n_i |=> status_oe_n_o) // RL25
    else $error("status pins driven while disabled");
  flush_zero_a: assert property ((s1.flush && s1.alu_sub) |-> ~|alu_rnd[62:0]) // RL16
    else $error("subnormal result not flushed");
  rnd_exact_a: assert property ((!alu_incr || alu_inx) && (!mul_incr || mul_inx)) // RL6
    else $error("round up while exact");
  nan_compare_flag_neq_a: assert property (nan_compare_flag_o |-> !operands_equal_flag_o // RL22
      && !a_greater_flag_o)
    else $error("unordered compare reported ordered");
endmodule

// ---- tb/fps_ctrl_model.sv ----
`timescale 1ns/1ps
// controller stand-in: turns an op kind into the qualifier lines
module fps_ctrl_model
  import fps_pkg::*;
(
  input  wire logic [1:0] kind_i,
  input  wire logic       alu_src_i,
  output logic            compare_op_o,
  output logic            mul_op_o,
  output logic            chain_mode_o,
  output logic [1:0]      chain_status_select_o,
  output logic            instruction_bit6_o,
  output logic [7:0]      operand_source_select_o
);
  // kind 0 alu, 1 compare, 2 multiply, 3 chained
  always_comb
  begin
    compare_op_o            = (kind_i == 2'h1);
    mul_op_o                = (kind_i == 2'h2);
    chain_mode_o            = (kind_i == 2'h3);
    chain_status_select_o   = alu_src_i ? CSS_ALU : CSS_MUL;
    instruction_bit6_o      = alu_src_i;
    operand_source_select_o = {6'h00, kind_i};
  end
endmodule

// ---- tb/fp_status_pipeline_control_bench.sv ----
`timescale 1ns/1ps
module fp_status_pipeline_control_bench;
  import fps_pkg::*;
  logic clk_i, resetn_i, alu_mul_pipe_enable_n_i, result_stage_pipe_enable_n_i;
  logic stall_n_i, sudden_underflow_i, round_mode_bit_lo_i, round_mode_bit_hi_i;
  logic result_half_select_i, c_reg_source_select_i, c_write_enable_n_i;
  logic status_output_enable_n_i, single_prec_i, mask_write_i, alu_subnormal_i;
  logic mul_wrapped_i, compare_op_i, mul_op_i, chain_mode_i, instruction_bit6_i;
  logic [1:0] chain_status_select_i, kind;
  logic alu_src;
  logic [EXC_W-1:0] mask_data_i;
  logic [63:0] op_a_i, op_b_i, mul_a_i, mul_b_i, alu_result_i, mul_result_i, c_reg_o;
  logic [2:0] alu_grs_i, mul_grs_i;
  logic [RAW_W-1:0] alu_raw_i, mul_raw_i;
  logic [31:0] y_o;
  logic status_oe_n_o, round_increment_flag_o, operands_equal_flag_o, a_greater_flag_o;
  logic chain_exception_source_o, multiplier_subnormal_input_flag_o;
  logic subnormal_output_flag_o, divide_by_zero_flag_o, any_exception_flag_o;
  logic imprecise_result_flag_o, result_unbounded_flag_o, invalid_operation_flag_o;
  logic result_sign_flag_o, exception_origin_flag_o, b_port_special_input_flag_o;
  logic a_port_special_input_flag_o, overflow_flag_o, underflow_flag_o, nan_compare_flag_o;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  fps_status_top i_fps_status_top (.*);

  fps_ctrl_model i_fps_ctrl_model (
    .kind_i                  (kind),
    .alu_src_i               (alu_src),
    .compare_op_o            (compare_op_i),
    .mul_op_o                (mul_op_i),
    .chain_mode_o            (chain_mode_i),
    .chain_status_select_o   (chain_status_select_i),
    .instruction_bit6_o      (instruction_bit6_i),
    .operand_source_select_o ()
  );

  // free-running 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // hang guard well above run length
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic run(int n);
    repeat (n) @(negedge clk_i);
  endtask

  // all inputs quiet, pipes registered; four cycles flush any earlier op
  task automatic idle();
    {alu_mul_pipe_enable_n_i, result_stage_pipe_enable_n_i, sudden_underflow_i} = 3'h0;
    {round_mode_bit_hi_i, round_mode_bit_lo_i, result_half_select_i, alu_subnormal_i} = 4'h0;
    {mul_wrapped_i, mask_write_i, kind, alu_src} = 5'h00;
    {c_reg_source_select_i, single_prec_i, c_write_enable_n_i, stall_n_i} = 4'h3;
    {op_a_i, op_b_i, mul_a_i, mul_b_i} = 256'h0;
    {alu_result_i, mul_result_i} = 128'h0;
    {alu_grs_i, mul_grs_i, alu_raw_i, mul_raw_i} = 14'h0;
    mask_data_i = 5'h00;
    run(4);
  endtask

  task automatic t_oe();
    status_output_enable_n_i = 1'b1;
    run(2);
    chk("oe off", 64'h1, status_oe_n_o);
    status_output_enable_n_i = 1'b0;
    run(1);
    chk("oe on", 64'h0, status_oe_n_o);
  endtask

  // latency drops by one edge per stage put in flowthrough
  task automatic t_pipes();
    for (int m = 0; m < 3; m++)
    begin
      idle();
      alu_mul_pipe_enable_n_i = (m > 0);
      result_stage_pipe_enable_n_i = (m > 1);
      run(2);
      alu_raw_i[RAW_DIV] = 1'b1;
      run(2 - m);
      chk("div early", 64'h0, divide_by_zero_flag_o);
      run(1);
      chk("div flag", 64'h1, divide_by_zero_flag_o);
    end
  endtask

  task automatic t_reset();
    idle();
    alu_result_i = 64'h1234_5678_9ABC_DEF0;
    mask_data_i = 5'h02;
    run(3);
    {mask_write_i, c_write_enable_n_i} = 2'h2;
    run(1);
    {mask_write_i, c_write_enable_n_i} = 2'h1;
    alu_raw_i[RAW_DIV] = 1'b1;
    run(4);
    chk("c sum", 64'h1234_5678_9ABC_DEF0, c_reg_o);
    chk("masked any", 64'h0, any_exception_flag_o);
    resetn_i = 1'b0;
    run(1);
    chk("reset div", 64'h0, divide_by_zero_flag_o);
    resetn_i = 1'b1;
    run(6);
    chk("unmasked any", 64'h1, any_exception_flag_o);
    chk("c kept", 64'h1234_5678_9ABC_DEF0, c_reg_o);
  endtask

  // guard and round set: each mode and sign gives a distinct pattern
  task automatic t_round();
    logic [3:0] inc;
    for (int s = 0; s < 2; s++)
      for (int m = 0; m < 4; m++)
      begin
        idle();
        inc = s ? 4'h9 : 4'h5;
        {round_mode_bit_hi_i, round_mode_bit_lo_i} = 2'(m);
        alu_result_i = {s[0], 63'h3FF0_0000_0000_0000};
        alu_grs_i = 3'h6;
        alu_raw_i[RAW_TNY] = 1'b1;
        run(3);
        chk("round incr", {63'h0, inc[m]}, round_increment_flag_o);
        chk("y rounded", {63'h0, inc[m]}, y_o);
        chk("underflow", 64'h1, underflow_flag_o);
        chk("neg", 64'(s), result_sign_flag_o);
        chk("inexact", 64'h1, imprecise_result_flag_o);
      end
  endtask

  task automatic cmp_case(logic [1:0] k, logic [63:0] a, logic [63:0] b, logic [3:0] e);
    idle();
    kind = k;
    {op_a_i, op_b_i} = {a, b};
    run(3);
    chk("eq", {63'h0, e[3]}, operands_equal_flag_o);
    chk("gt", {63'h0, e[2]}, a_greater_flag_o);
    chk("nan_compare_flag", {63'h0, e[1]}, nan_compare_flag_o);
    chk("invalid", {63'h0, e[0]}, invalid_operation_flag_o);
  endtask

  task automatic t_chain();
    for (int s = 0; s < 2; s++)
    begin
      idle();
      {kind, alu_src, mul_raw_i} = {2'h3, s[0], 4'h2};
      run(3);
      chk("chain_exception_source", 64'(!s[0]), chain_exception_source_o);
      chk("chain div", 64'(!s[0]), divide_by_zero_flag_o);
      chk("origin", 64'(!s[0]), exception_origin_flag_o);
    end
  endtask

  task automatic t_cmp();
    cmp_case(2'h1, 64'h4000_0000_0000_0000, 64'h3FF0_0000_0000_0000, 4'h4);
    cmp_case(2'h1, 64'h3FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000, 4'h8);
    cmp_case(2'h1, 64'h7FF8_0000_0000_0000, 64'h7FF8_0000_0000_0001, 4'h3);
    cmp_case(2'h0, 64'h3FF0_0000_0000_0000, 64'h4000_0000_0000_0000, 4'h8);
  endtask

  task automatic t_half();
    idle();
    alu_result_i = 64'hAAAA_BBBB_CCCC_DDDD;
    mul_result_i = 64'h1111_2222_3333_4444;
    {result_half_select_i, c_reg_source_select_i} = 2'h3;
    run(3);
    chk("y high", 64'hAAAA_BBBB, y_o);
    c_write_enable_n_i = 1'b0;
    run(1);
    c_write_enable_n_i = 1'b1;
    result_half_select_i = 1'b0;
    run(3);
    chk("c product", 64'h1111_2222_3333_4444, c_reg_o);
    chk("y low", 64'hCCCC_DDDD, y_o);
  endtask

  task automatic t_subn();
    idle();
    kind = 2'h2;
    mul_a_i = 64'h0000_0000_0000_0001;
    mul_wrapped_i = 1'b1;
    run(3);
    chk("den in", 64'h1, multiplier_subnormal_input_flag_o);
    chk("a port", 64'h1, a_port_special_input_flag_o);
    chk("b port", 64'h0, b_port_special_input_flag_o);
    chk("wrapped", 64'h1, subnormal_output_flag_o);
    idle();
    alu_result_i = 64'h0000_0000_0000_0005;
    {alu_subnormal_i, sudden_underflow_i} = 2'h3;
    run(3);
    chk("flushed y", 64'h0, y_o);
    chk("alu subn", 64'h1, subnormal_output_flag_o);
    sudden_underflow_i = 1'b0;
    run(3);
    chk("gradual y", 64'h5, y_o);
  endtask

  // stall freezes flags while the raw inputs fall
  task automatic t_stall();
    idle();
    alu_raw_i = 4'h5;
    run(3);
    chk("ovf", 64'h1, overflow_flag_o);
    chk("inv", 64'h1, invalid_operation_flag_o);
    stall_n_i = 1'b0;
    alu_raw_i = 4'h0;
    run(4);
    chk("held ovf", 64'h1, overflow_flag_o);
    stall_n_i = 1'b1;
    run(3);
    chk("ovf gone", 64'h0, overflow_flag_o);
  endtask

  // reset held 16 cycles, first op three edges after release
  initial
  begin
    resetn_i = 1'b0;
    status_output_enable_n_i = 1'b0;
    idle();
    run(12);
    resetn_i = 1'b1;
    run(3);
    t_oe();
    t_pipes();
    t_reset();
    t_round();
    t_cmp();
    t_chain();
    t_half();
    t_subn();
    t_stall();
    wrap_up();
  end
endmodule
